// ### logic/fault_input_override.v
// fault input enables and output override enables of the fault detect unit
// assumes a single clock, synchronous reset and a simple strobe register port
`timescale 1ns/1ns
`include "fault_unit_regs.vh"
module fault_input_override #(
  parameter N = 8
) (
  // clock and reset
  input  wire              CLK,
  input  wire              SRST,
  // register port
  input  wire [15:0]       ADDR,
  input  wire [7:0]        WDATA,
  input  wire              WR,
  input  wire              RD,
  output reg  [7:0]        RDATA,
  // fault sources, active high
  input  wire [N-1:0]      FAULT_IN,
  // normal source signals
  input  wire [N-1:0]      SRC_OUT,
  input  wire [N-1:0]      SRC_OE,
  // guarded pins
  output wire [N-1:0]      GUARDED_OUT,
  output wire [N-1:0]      GUARDED_OE,
  // status
  output wire              FAULT_FLAG,
  output wire              UNIT_ENABLE
);
  // ****************************************
  // registers
  // ****************************************
  reg  [7:0] fault_input_enable_reg;
  reg  [7:0] output_override_enable_reg;
  reg  [7:0] override_direction_reg;
  reg  [7:0] override_drive_value_reg;
  reg        unit_enable_reg;
  reg        fault_flag_reg;
  wire       fault_hit;
  wire       flag_clear;
  reg  [7:0] rdata_next;

  // ****************************************
  // address decode
  // ****************************************
  wire       sel_input_en;
  wire       sel_override_en;
  wire       sel_override_dir;
  wire       sel_override_val;
  wire       sel_unit_ctrl;
  wire       wr_input_en;
  wire       wr_override_en;
  wire       wr_override_dir;
  wire       wr_override_val;
  wire       wr_unit_ctrl;

  assign sel_input_en     = (ADDR == `OFF_FAULT_INPUT_EN);
  assign sel_override_en  = (ADDR == `OFF_OVERRIDE_EN);
  assign sel_override_dir = (ADDR == `OFF_OVERRIDE_DIR);
  assign sel_override_val = (ADDR == `OFF_OVERRIDE_VAL);
  assign sel_unit_ctrl    = (ADDR == `OFF_UNIT_CTRL);
  assign wr_input_en      = WR & sel_input_en;
  assign wr_override_en   = WR & sel_override_en;
  assign wr_override_dir  = WR & sel_override_dir;
  assign wr_override_val  = WR & sel_override_val;
  assign wr_unit_ctrl     = WR & sel_unit_ctrl;

  // ****************************************
  // fault gating
  // ****************************************
  wire [N-1:0] fault_gated;

  genvar j;
  generate
    for (j = 0; j < N; j = j + 1) begin : gate
      assign fault_gated[j] = FAULT_IN[j] & fault_input_enable_reg[j];
    end
  endgenerate

  assign fault_hit  = unit_enable_reg & (|fault_gated);
  assign flag_clear = wr_unit_ctrl & ~WDATA[`CTRL_FLAG_BIT];

  // ****************************************
  // fault input enable
  // ****************************************
  always @(posedge CLK) begin
    if (SRST) begin
      fault_input_enable_reg <= `RST_BYTE;
    end else if (wr_input_en) begin
      fault_input_enable_reg <= WDATA;
    end
  end

  // ****************************************
  // output override enable
  // ****************************************
  always @(posedge CLK) begin
    if (SRST) begin
      output_override_enable_reg <= `RST_BYTE;
    end else if (wr_override_en) begin
      output_override_enable_reg <= WDATA;
    end
  end

  // ****************************************
  // override direction
  // ****************************************
  always @(posedge CLK) begin
    if (SRST) begin
      override_direction_reg <= `RST_BYTE;
    end else if (wr_override_dir) begin
      override_direction_reg <= WDATA;
    end
  end

  // ****************************************
  // override drive value
  // ****************************************
  always @(posedge CLK) begin
    if (SRST) begin
      override_drive_value_reg <= `RST_BYTE;
    end else if (wr_override_val) begin
      override_drive_value_reg <= WDATA;
    end
  end

  // ****************************************
  // unit enable
  // ****************************************
  always @(posedge CLK) begin
    if (SRST) begin
      unit_enable_reg <= 1'b0;
    end else if (wr_unit_ctrl) begin
      unit_enable_reg <= WDATA[`CTRL_UNIT_EN_BIT];
    end
  end

  // ****************************************
  // fault flag
  // ****************************************
  always @(posedge CLK) begin
    if (SRST) begin
      fault_flag_reg <= 1'b0;
    end else begin
      // set wins over clear
      if (fault_hit) begin
        fault_flag_reg <= 1'b1;
      end else if (flag_clear) begin
        fault_flag_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always @* begin
    case (ADDR)
      `OFF_FAULT_INPUT_EN: rdata_next = fault_input_enable_reg;
      `OFF_OVERRIDE_EN:    rdata_next = output_override_enable_reg;
      `OFF_OVERRIDE_DIR:   rdata_next = override_direction_reg;
      `OFF_OVERRIDE_VAL:   rdata_next = override_drive_value_reg;
      `OFF_UNIT_CTRL:      rdata_next = {fault_flag_reg, 6'h00, unit_enable_reg};
      default:             rdata_next = 8'h00;
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      RDATA <= rdata_next;
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ****************************************
  // pin lanes
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : lane
      pin_override_lane u_lane (
        .unit_en     (unit_enable_reg),
        .override_en (output_override_enable_reg[i]),
        .dir         (override_direction_reg[i]),
        .val         (override_drive_value_reg[i]),
        .src_out     (SRC_OUT[i]),
        .src_oe      (SRC_OE[i]),
        .pin_out     (GUARDED_OUT[i]),
        .pin_oe      (GUARDED_OE[i])
      );
    end
  endgenerate

  // ****************************************
  // status outputs
  // ****************************************

  assign FAULT_FLAG  = fault_flag_reg;
  assign UNIT_ENABLE = unit_enable_reg;
endmodule

// ### logic/fault_unit_regs.vh
// register offsets, field positions, reset values for the fault input and override enable block
// assumes a byte-wide register port at the absolute addresses below
`ifndef FAULT_UNIT_REGS_VH
`define FAULT_UNIT_REGS_VH

`define ADDR_W              16
`define DATA_W              8
`define OFF_FAULT_INPUT_EN  16'h30DE
`define OFF_OVERRIDE_EN     16'h30DF
`define OFF_OVERRIDE_DIR    16'h30E0
`define OFF_OVERRIDE_VAL    16'h30E1
`define OFF_UNIT_CTRL       16'h30E8
`define RST_BYTE            8'h00
`define CTRL_UNIT_EN_BIT    0
`define CTRL_FLAG_BIT       7

`endif

// ### logic/pin_override_lane.v
// one guarded output pin: bypass or override by direction and value
// assumes all inputs synchronous to the caller's clock
`timescale 1ns/1ns
module pin_override_lane (
  // control
  input  wire unit_en,
  input  wire override_en,
  input  wire dir,
  input  wire val,
  // normal source
  input  wire src_out,
  input  wire src_oe,
  // pin
  output wire pin_out,
  output wire pin_oe
);
  wire take;
  assign take    = unit_en & override_en;
  assign pin_oe  = take ? dir : src_oe;
  assign pin_out = take ? (dir & val) : src_out;
endmodule

// ### tb/fio_chk.sv
// port checker for the fault input and override enable block
// assumes bind onto fault_input_override
`timescale 1ns/1ns
module fio_chk #(parameter N = 8) (
  input wire         CLK, SRST, WR, RD, FAULT_FLAG, UNIT_ENABLE,
  input wire [15:0]  ADDR,
  input wire [7:0]   WDATA, RDATA,
  input wire [N-1:0] FAULT_IN, SRC_OUT, SRC_OE, GUARDED_OUT, GUARDED_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  a_bypass_when_off: assert property (!UNIT_ENABLE |-> GUARDED_OUT == SRC_OUT && GUARDED_OE == SRC_OE)
    else $error("pins not bypassed");
  a_reset_clears: assert property (disable iff (1'b0) SRST |=> !FAULT_FLAG && !UNIT_ENABLE && RDATA == 8'h00)
    else $error("reset state wrong");
  a_rdata_idle: assert property (!RD |=> RDATA == 8'h00) else $error("read data without read");
  a_flag_sticky: assert property (FAULT_FLAG && !WR |=> FAULT_FLAG) else $error("flag dropped");
  a_no_fault_off: assert property (!UNIT_ENABLE && !FAULT_FLAG |=> !FAULT_FLAG) else $error("flag while off");
  a_flag_cause: assert property ($rose(FAULT_FLAG) |-> $past(UNIT_ENABLE && FAULT_IN != 0))
    else $error("flag without fault");
  a_enable_readback: assert property ((WR && ADDR == 16'h30DE) ##1 !WR ##1 (RD && ADDR == 16'h30DE)
    |=> RDATA == $past(WDATA, 3)) else $error("enable readback");
  a_unit_stable: assert property (!WR |=> $stable(UNIT_ENABLE)) else $error("unit enable moved");
endmodule
bind fault_input_override fio_chk #(.N(N)) chk (.CLK(CLK), .SRST(SRST), .WR(WR), .RD(RD), .FAULT_FLAG(FAULT_FLAG),
  .UNIT_ENABLE(UNIT_ENABLE), .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .FAULT_IN(FAULT_IN), .SRC_OUT(SRC_OUT),
  .SRC_OE(SRC_OE), .GUARDED_OUT(GUARDED_OUT), .GUARDED_OE(GUARDED_OE));

// ### tb/testbench.sv
// register-level testbench for the fault input and override enable block
// assumes the strobe register port with read data one cycle later
`timescale 1ns/1ns
module testbench;
  reg         CLK = 0, SRST = 1, WR = 0, RD = 0;
  reg [15:0]  ADDR = 16'h0000;
  reg [7:0]   WDATA = 8'h00, FAULT_IN = 8'h00, SRC_OUT = 8'hAA, SRC_OE = 8'hF0, p = 8'h00;
  wire [7:0]  RDATA, GUARDED_OUT, GUARDED_OE;
  wire        FAULT_FLAG, UNIT_ENABLE;
  integer     miscompares = 0, tests_run = 0, cyc = 0;
  fault_input_override dut (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .FAULT_IN(FAULT_IN), .SRC_OUT(SRC_OUT), .SRC_OE(SRC_OE), .GUARDED_OUT(GUARDED_OUT), .GUARDED_OE(GUARDED_OE),
    .FAULT_FLAG(FAULT_FLAG), .UNIT_ENABLE(UNIT_ENABLE));
  always #50 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  task conclude;
    begin
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    begin
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(RDATA, e);
    end
  endtask
  initial begin
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    rd(16'h30DE, 8'h00);
    rd(16'h30DF, 8'h00);
    chk(GUARDED_OUT, SRC_OUT);
    wr(16'h30DE, 8'hA5);
    rd(16'h30DE, 8'hA5);
    wr(16'h30E2, 8'hFF);
    rd(16'h30E2, 8'h00);
    wr(16'h30E8, 8'h01);
    wr(16'h30E0, 8'h0F);
    wr(16'h30E1, 8'h33);
    repeat (2) begin
      p = (p == 8'hFF) ? 8'h55 : 8'hFF;
      wr(16'h30DF, p);
      rd(16'h30DF, p);
      chk(GUARDED_OE, (8'h0F & p) | (SRC_OE & ~p));
      chk(GUARDED_OUT, (8'h03 & p) | (SRC_OUT & ~p));
    end
    FAULT_IN <= 8'h5A;
    rd(16'h30DE, 8'hA5);
    chk(FAULT_FLAG, 8'h00);
    wr(16'h30DE, 8'hA7);
    rd(16'h30E8, 8'h81);
    FAULT_IN <= 8'h00;
    wr(16'h30E8, 8'h00);
    FAULT_IN <= 8'hFF;
    rd(16'h30E8, 8'h00);
    chk(GUARDED_OE, SRC_OE);
    chk(GUARDED_OUT, SRC_OUT);
    chk(UNIT_ENABLE, 8'h00);
    conclude;
  end
endmodule
